// File: core/mc_upconv.sv
// Behaviour
// - Slot a passes original field unchanged
// - Slot c is line interpolation of field
// - Slots b and d use motion vectors
// - Five-tap median: two displaced pixels, field average, lines above/below
// - Absent line uses lines above and below
// - Field average tap gives local fallback
// - Output sequence follows camera/film mode
// - Camera mode: every field new phase
// - PAL film: field pairs share phase
// - NTSC film: 2-3 cadence of phases
// - Penalty added to non-null candidates
// - Enable selects unfiltered null difference
`timescale 1ns/100ps
`include "mc_upconv_params.svh"

module mc_out_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  // Clock and control
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wp_r, wp_nxt; // Write pointer
  logic [AW:0] rp_r, rp_nxt; // Read pointer
  logic [AW:0] cnt; // Fill level
  logic push, pop;
  // Level and handshakes
  always_comb begin
    cnt = wp_r - rp_r;
    in_ready = (cnt != (AW+1)'(DEPTH));
    out_valid = (cnt != '0);
    push = ce && in_valid && in_ready;
    pop = ce && out_valid && out_ready;
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    out_data = mem[rp_r[AW-1:0]];
  end
  // Pointer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end
  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_fifo_full: assert property (cnt <= (AW+1)'(DEPTH))
    else $error("fifo level above depth");
  c_fifo_fill: cover property (!in_ready);
endmodule : mc_out_fifo

module mc_upconv #(
  parameter int PW = `PIX_W,
  parameter int CW = `COST_W,
  parameter int DEPTH = `OUT_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // Control register write port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // Field control
  input wire logic field_start,
  input wire mc_upconv_pkg::film_mode_t mode_in,
  input wire logic cadence_sync,
  // Pixel stream in
  input wire logic px_valid,
  input wire mc_upconv_pkg::pix_in_t px,
  output logic px_ready,
  // Pixel stream out
  output logic out_valid,
  output logic [PW-1:0] out_pix,
  input wire logic out_ready,
  // Estimator candidate cost
  input wire mc_upconv_pkg::cand_t cand,
  output logic [CW-1:0] cand_cost,
  output logic cand_cost_valid,
  // Estimator controls and status
  output logic vector_smoothing_enable,
  output logic vector_correction_enable,
  output mc_upconv_pkg::slot_t slot_out,
  output mc_upconv_pkg::film_mode_t mode_out,
  output logic phase_new_out
);
  logic [7:0] ctl_r, ctl_nxt; // Smoothing/null byte
  logic [7:0] nonnull_vector_penalty_r, pen_nxt; // Penalty byte
  logic [7:0] vcorr_r, vcorr_nxt; // Correction byte
  mc_upconv_pkg::slot_t slot_r, slot_nxt; // Output slot
  mc_upconv_pkg::film_mode_t mode_r, mode_nxt; // Sampled mode
  logic [2:0] cad_r, cad_nxt; // Cadence position
  logic in_bound; // Next field starts an input field
  logic phase_new; // Current input field has a new phase
  logic [PW-1:0] prev_mc, next_mc, avg, intra, tap_p, res;
  logic push, fifo_rdy;
  logic [CW-1:0] cost_r, cost_nxt, dsel;
  logic cv_r, cv_nxt;
  logic [CW:0] sum;
  // Rounded mean of two pixels
  function automatic logic [PW-1:0] avg2(input logic [PW-1:0] x,
                                         input logic [PW-1:0] y);
    logic [PW:0] s;
    s = {1'b0, x} + {1'b0, y} + (PW+1)'(1);
    return s[PW:1];
  endfunction : avg2
  // Displaced pixel, averaged when the line is absent
  function automatic logic [PW-1:0] disp(input logic [PW-1:0] up,
                                         input logic [PW-1:0] lo,
                                         input logic half);
    return half ? avg2(up, lo) : up;
  endfunction : disp
  // Median of five by rank counting
  function automatic logic [PW-1:0] med5(input logic [4:0][PW-1:0] t);
    logic [PW-1:0] m;
    int lt;
    int le;
    m = t[0];
    for (int i = 0; i < 5; i++) begin
      lt = 0;
      le = 0;
      for (int j = 0; j < 5; j++) begin
        if (t[j] < t[i]) lt++;
        if (t[j] <= t[i]) le++;
      end
      if (lt <= 2 && le >= 3) m = t[i];
    end
    return m;
  endfunction : med5
  // Register writes by sub-address
  always_comb begin
    ctl_nxt = ctl_r;
    pen_nxt = nonnull_vector_penalty_r;
    vcorr_nxt = vcorr_r;
    if (reg_wr) begin
      case (reg_addr)
        `SUB_SMOOTH_NULL: ctl_nxt = reg_wdata;
        `SUB_PENALTY: pen_nxt = reg_wdata;
        `SUB_VCORR: vcorr_nxt = reg_wdata;
        default: ;
      endcase
    end
  end
  // Control register bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_r <= `RST_SMOOTH_NULL;
      nonnull_vector_penalty_r <= `RST_PENALTY;
      vcorr_r <= `RST_VCORR;
    end else if (ce) begin
      ctl_r <= ctl_nxt;
      nonnull_vector_penalty_r <= pen_nxt;
      vcorr_r <= vcorr_nxt;
    end
  end
  // Field sequencer and cadence tracker
  always_comb begin
    in_bound = (slot_r == mc_upconv_pkg::slot_b) ||
               (slot_r == mc_upconv_pkg::slot_d);
    slot_nxt = slot_r;
    mode_nxt = mode_r;
    cad_nxt = cad_r;
    if (field_start) begin
      case (slot_r)
        mc_upconv_pkg::slot_a: slot_nxt = mc_upconv_pkg::slot_b;
        mc_upconv_pkg::slot_b: slot_nxt = mc_upconv_pkg::slot_c;
        mc_upconv_pkg::slot_c: slot_nxt = mc_upconv_pkg::slot_d;
        default: slot_nxt = mc_upconv_pkg::slot_a;
      endcase
      mode_nxt = mode_in;
      if (cadence_sync || mode_in != mode_r) begin
        cad_nxt = '0;
      end else if (in_bound) begin
        case (mode_r)
          mc_upconv_pkg::mode_pal_film:
            cad_nxt = (cad_r + 3'h1 >= `CAD_PAL) ? '0 : cad_r + 3'h1;
          mc_upconv_pkg::mode_ntsc_film:
            cad_nxt = (cad_r + 3'h1 >= `CAD_NTSC) ? '0 : cad_r + 3'h1;
          default: cad_nxt = '0;
        endcase
      end
    end
  end
  // Sequencer registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slot_r <= mc_upconv_pkg::slot_a;
      mode_r <= mc_upconv_pkg::mode_camera;
      cad_r <= '0;
    end else if (ce) begin
      slot_r <= slot_nxt;
      mode_r <= mode_nxt;
      cad_r <= cad_nxt;
    end
  end
  // Pixel synthesis per slot
  always_comb begin
    case (mode_r)
      mc_upconv_pkg::mode_pal_film: phase_new = (cad_r == '0);
      mc_upconv_pkg::mode_ntsc_film:
        phase_new = (cad_r == '0) || (cad_r == `CAD_NTSC_2ND);
      default: phase_new = 1'b1;
    endcase
    prev_mc = disp(px.prev_up, px.prev_lo, px.vec_half);
    next_mc = disp(px.next_up, px.next_lo, px.vec_half);
    avg = avg2(px.prev_co, px.next_co);
    intra = avg2(px.a_up, px.a_lo);
    // Repeated film phase: both taps from the new-phase side
    tap_p = phase_new ? prev_mc : next_mc;
    case (slot_r)
      mc_upconv_pkg::slot_a: res = px.orig;
      mc_upconv_pkg::slot_c: res = intra;
      default: res = med5({tap_p, next_mc, avg, px.a_up, px.a_lo});
    endcase
    px_ready = ce && fifo_rdy;
    push = px_valid && px_ready;
  end
  // Output buffer, drain stalls the pixel path
  mc_out_fifo #(.W(PW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(px_valid),
    .in_data(res),
    .in_ready(fifo_rdy),
    .out_valid(out_valid),
    .out_data(out_pix),
    .out_ready(out_ready)
  );
  // Candidate cost with penalty and null select
  always_comb begin
    dsel = (cand.is_null && ctl_r[`BIT_RAW_NULL]) ? cand.raw_diff
                                                   : cand.diff;
    sum = {1'b0, dsel} + (cand.is_null ? '0
          : (CW+1)'(nonnull_vector_penalty_r));
    cost_nxt = sum[CW] ? '1 : sum[CW-1:0];
    cv_nxt = cand.valid;
  end
  // Cost registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cost_r <= '0;
      cv_r <= 1'b0;
    end else if (ce) begin
      cost_r <= cost_nxt;
      cv_r <= cv_nxt;
    end
  end

  // Outputs
  assign cand_cost = cost_r;
  assign cand_cost_valid = cv_r;
  assign vector_smoothing_enable = ctl_r[`BIT_SMOOTH];
  assign vector_correction_enable = vcorr_r[`BIT_VCORR];
  assign slot_out = slot_r;
  assign mode_out = mode_r;
  assign phase_new_out = phase_new;

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_orig_pass: assert property (
    push && slot_r == mc_upconv_pkg::slot_a |-> res == px.orig)
    else $error("slot a not original");
  a_intra_line: assert property (
    push && slot_r == mc_upconv_pkg::slot_c |->
    res == avg2(px.a_up, px.a_lo))
    else $error("slot c not interpolated");
  a_median_agree: assert property (
    push && slot_r == mc_upconv_pkg::slot_b && tap_p == next_mc &&
    (avg <= next_mc || px.a_up <= next_mc || px.a_lo <= next_mc) &&
    (avg >= next_mc || px.a_up >= next_mc || px.a_lo >= next_mc) |->
    res == next_mc)
    else $error("agreeing vectors not chosen");
  a_median_range: assert property (
    push && slot_r == mc_upconv_pkg::slot_d |->
    res == tap_p || res == next_mc || res == avg ||
    res == px.a_up || res == px.a_lo)
    else $error("median output not a tap");
  a_absent_line: assert property (
    px.vec_half |-> prev_mc == avg2(px.prev_up, px.prev_lo))
    else $error("absent line not averaged");
  a_mode_hold: assert property (
    ce && !field_start |=> $stable(mode_r))
    else $error("mode changed mid field");
  a_cam_phase: assert property (
    mode_r == mc_upconv_pkg::mode_camera |-> phase_new)
    else $error("camera field not new phase");
  a_pal_pair: assert property (
    ce && field_start && in_bound && !cadence_sync &&
    mode_r == mc_upconv_pkg::mode_pal_film && mode_in == mode_r
    |=> phase_new != $past(phase_new))
    else $error("pal phase did not alternate");
  a_ntsc_cad: assert property (
    mode_r == mc_upconv_pkg::mode_ntsc_film |-> cad_r < `CAD_NTSC)
    else $error("ntsc cadence out of range");
  a_penalty_add: assert property (
    ce && !cand.is_null && !ctl_r[`BIT_RAW_NULL] &&
    {1'b0, cand.diff} + (CW+1)'(nonnull_vector_penalty_r) < (CW+1)'(1 << CW)
    |=> cost_r == $past(cand.diff) + CW'($past(nonnull_vector_penalty_r)))
    else $error("penalty not applied");
  a_raw_null: assert property (
    ce && cand.is_null && ctl_r[`BIT_RAW_NULL]
    |=> cost_r == $past(cand.raw_diff))
    else $error("raw null difference not used");
  c_pal_mode: cover property (mode_r == mc_upconv_pkg::mode_pal_film && push);
  c_ntsc_repeat: cover property (
    mode_r == mc_upconv_pkg::mode_ntsc_film && !phase_new && push);
  c_stall: cover property (px_valid && !px_ready);
endmodule : mc_upconv

// File: core/mc_upconv_params.svh
`ifndef MC_UPCONV_PARAMS_SVH
`define MC_UPCONV_PARAMS_SVH
// Sub-addresses of the write-only control registers
`define SUB_SMOOTH_NULL 8'h4b
`define SUB_PENALTY 8'h4c
`define SUB_VCORR 8'h4e
// Field positions inside the control bytes
`define BIT_SMOOTH 0
`define BIT_RAW_NULL 1
`define BIT_VCORR 0
// Reset values
`define RST_SMOOTH_NULL 8'h00
`define RST_PENALTY 8'h00
`define RST_VCORR 8'h00
// Data widths
`define PIX_W 8
`define COST_W 12
// Cadence lengths in input fields, and NTSC second-phase start position
`define CAD_PAL 3'h2
`define CAD_NTSC 3'h5
`define CAD_NTSC_2ND 3'h2
// Output buffer depth
`define OUT_DEPTH 8
`endif

// File: core/mc_upconv_pkg.sv
`include "mc_upconv_params.svh"
package mc_upconv_pkg;
  // Source cadence indication
  typedef enum logic [1:0] {mode_camera, mode_pal_film, mode_ntsc_film}
    film_mode_t;
  // Output field slot within one input pair
  typedef enum logic [1:0] {slot_a, slot_b, slot_c, slot_d} slot_t;
  // Pixel taps for one output pixel
  typedef struct packed {
    logic [`PIX_W-1:0] orig;
    logic [`PIX_W-1:0] a_up;
    logic [`PIX_W-1:0] a_lo;
    logic [`PIX_W-1:0] prev_up;
    logic [`PIX_W-1:0] prev_lo;
    logic [`PIX_W-1:0] prev_co;
    logic [`PIX_W-1:0] next_up;
    logic [`PIX_W-1:0] next_lo;
    logic [`PIX_W-1:0] next_co;
    logic vec_half;
  } pix_in_t;
  // Estimator candidate
  typedef struct packed {
    logic valid;
    logic is_null;
    logic [`COST_W-1:0] diff;
    logic [`COST_W-1:0] raw_diff;
  } cand_t;
endpackage : mc_upconv_pkg

// File: tb/mc_display_sink.sv
`timescale 1ns/100ps
// Display path model: takes pixels, can stall or run at half rate
module mc_display_sink (
  // Clock
  input wire logic clk,
  input wire logic ce,
  // Stream from the converter
  input wire logic out_valid,
  input wire logic [7:0] out_pix,
  output logic out_ready,
  // Pace set by the bench
  input wire logic stall,
  input wire logic slow
);
  logic [7:0] got_q[$]; // Pixels taken, in order
  logic odd = 1'b0; // Toggles for the slow pace
  initial out_ready = 1'b0;
  // Take on handshake, move ready just after the edge
  always @(posedge clk) begin
    if (ce && out_valid && out_ready)
      got_q.push_back(out_pix);
    odd <= !odd;
    out_ready <= #1 !stall && (!slow || odd);
  end
endmodule : mc_display_sink

// File: tb/test_mc_upconv.sv
`timescale 1ns/100ps
module test_mc_upconv;
  // Stimulus
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic field_start = 1'b0;
  logic cadence_sync = 1'b0;
  logic px_valid = 1'b0;
  logic stall = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  mc_upconv_pkg::film_mode_t mode_in = mc_upconv_pkg::mode_camera;
  mc_upconv_pkg::pix_in_t px = '0;
  mc_upconv_pkg::cand_t cand = '0;
  // Observed
  logic px_ready, out_valid, out_ready, cost_valid, smooth_en, vcorr_en;
  logic phase_new;
  logic [7:0] out_pix;
  logic [11:0] cand_cost;
  mc_upconv_pkg::slot_t slot_out;
  mc_upconv_pkg::film_mode_t mode_out;
  // Bookkeeping and reference model state
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int slot = 0;
  int cad = 0;
  int nf[3] = '{8, 12, 4};
  int cl[3] = '{2, 5, 1};
  logic pn;
  logic [7:0] exp_q[$];
  mc_upconv_pkg::film_mode_t ml[3] = '{mc_upconv_pkg::mode_pal_film,
    mc_upconv_pkg::mode_ntsc_film, mc_upconv_pkg::mode_camera};
  // Agreeing taps, disagreeing taps, whole-line vectors
  mc_upconv_pkg::pix_in_t pat[3] = '{
    {8'h5a, 8'h05, 8'h06, 8'h0a, 8'h1e, 8'h50, 8'h12, 8'h16, 8'h5a, 1'b1},
    {8'h33, 8'h70, 8'h90, 8'h00, 8'h00, 8'h80, 8'hf0, 8'hf0, 8'h80, 1'b1},
    {8'hc3, 8'h11, 8'h20, 8'h40, 8'hff, 8'h22, 8'h44, 8'h01, 8'h66, 1'b0}};

  mc_upconv i_dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .field_start(field_start), .mode_in(mode_in),
    .cadence_sync(cadence_sync), .px_valid(px_valid), .px(px),
    .px_ready(px_ready), .out_valid(out_valid), .out_pix(out_pix),
    .out_ready(out_ready), .cand(cand), .cand_cost(cand_cost),
    .cand_cost_valid(cost_valid), .vector_smoothing_enable(smooth_en),
    .vector_correction_enable(vcorr_en), .slot_out(slot_out),
    .mode_out(mode_out), .phase_new_out(phase_new));

  mc_display_sink i_sink (.clk(clk), .ce(ce), .out_valid(out_valid),
    .out_pix(out_pix), .out_ready(out_ready), .stall(stall), .slow(slow));

  // 10 MHz clock
  always #50 clk = !clk;

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test;
    end
  end

  // Rounded mean of two pixels
  function automatic logic [7:0] mn(input logic [7:0] u, input logic [7:0] l);
    return 8'((9'(u) + 9'(l) + 9'h001) >> 1);
  endfunction : mn

  // Expected output pixel for a slot and phase
  function automatic logic [7:0] model(input mc_upconv_pkg::pix_in_t p,
                                       input int s, input logic ph);
    logic [7:0] v[5];
    logic [7:0] pm, nm;
    int lt, le;
    pm = p.vec_half ? mn(p.prev_up, p.prev_lo) : p.prev_up;
    nm = p.vec_half ? mn(p.next_up, p.next_lo) : p.next_up;
    if (s == 0)
      return p.orig;
    if (s == 2)
      return mn(p.a_up, p.a_lo);
    v = '{ph ? pm : nm, nm, mn(p.prev_co, p.next_co), p.a_up, p.a_lo};
    foreach (v[i]) begin
      lt = 0;
      le = 0;
      foreach (v[j]) begin
        lt += int'(v[j] < v[i]);
        le += int'(v[j] <= v[i]);
      end
      if (lt <= 2 && le >= 3)
        return v[i];
    end
    return 8'h00;
  endfunction : model

  task tick;
    @(posedge clk);
    #1;
  endtask : tick

  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Control byte write, one-cycle strobe
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick;
    reg_wr = 1'b0;
    tick;
  endtask : wr

  // Candidate in, cost one cycle later
  task cost(input logic n, input logic [11:0] d, input logic [11:0] r,
            input logic [11:0] e);
    cand = {1'b1, n, d, r};
    tick;
    chk("cand_cost", 16'(cand_cost), 16'(e));
    chk("cost_valid", 16'(cost_valid), 16'h0001);
  endtask : cost

  // Offer one pixel and hold it until taken
  task send(input mc_upconv_pkg::pix_in_t p, input logic [7:0] e);
    px = p;
    px_valid = 1'b1;
    @(negedge clk);
    while (!px_ready)
      @(negedge clk);
    tick;
    exp_q.push_back(e);
  endtask : send

  task fpulse(input mc_upconv_pkg::film_mode_t m, input logic sy);
    mode_in = m;
    cadence_sync = sy;
    field_start = 1'b1;
    tick;
    field_start = 1'b0;
    cadence_sync = 1'b0;
  endtask : fpulse

  // Wait for the sink, then compare in order
  task drain;
    for (int i = 0; i < 400 && i_sink.got_q.size() != exp_q.size(); i++)
      tick;
    chk("count", 16'(i_sink.got_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i])
      chk("pix", 16'(i_sink.got_q[i]), 16'(exp_q[i]));
    exp_q.delete();
    i_sink.got_q.delete();
  endtask : drain

  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk("slot", 16'(slot_out), 16'h0000);
    chk("mode", 16'(mode_out), 16'h0000);
    chk("phase_new", 16'(phase_new), 16'h0001);
    chk("idle", 16'({smooth_en, vcorr_en, out_valid, cost_valid}), 16'h0000);
    cost(1'b0, 12'h064, 12'h000, 12'h064);
    wr(8'h4c, 8'h05);
    wr(8'h4b, 8'h03);
    wr(8'h4e, 8'h01);
    wr(8'h4d, 8'hff);
    chk("enables", 16'({smooth_en, vcorr_en}), 16'h0003);
    cost(1'b0, 12'h064, 12'h000, 12'h069);
    cost(1'b1, 12'h014, 12'h007, 12'h007);
    cost(1'b0, 12'hfff, 12'h000, 12'hfff);
    wr(8'h4b, 8'h01);
    cost(1'b1, 12'h014, 12'h007, 12'h014);
    // Every mode through all slots, sink at half rate
    slow = 1'b1;
    for (int m = 0; m < 3; m++) begin
      for (int f = 0; f < nf[m]; f++) begin
        fpulse(ml[m], f == 0);
        if (f == 0)
          cad = 0;
        else if (slot == 1 || slot == 3)
          cad = (cad + 1) % cl[m];
        slot = (slot + 1) % 4;
        pn = m == 2 || cad == 0 || (m == 1 && cad == 2);
        chk("slot", 16'(slot_out), 16'(slot));
        chk("mode", 16'(mode_out), 16'(ml[m]));
        chk("phase_new", 16'(phase_new), 16'(pn));
        for (int k = 0; k < 3; k++)
          send(pat[k], model(pat[k], slot, pn));
        px_valid = 1'b0;
      end
    end
    drain;
    // Mode held between field boundaries
    mode_in = mc_upconv_pkg::mode_ntsc_film;
    tick;
    tick;
    chk("mode", 16'(mode_out), 16'h0000);
    // Fill the buffer against a stalled sink
    stall = 1'b1;
    slow = 1'b0;
    tick;
    repeat (8)
      send(pat[2], 8'hc3);
    @(negedge clk);
    chk("px_ready", 16'(px_ready), 16'h0000);
    tick;
    // Ninth pixel held until the sink frees a slot
    stall = 1'b0;
    send(pat[2], 8'hc3);
    px_valid = 1'b0;
    drain;
    chk("out_valid", 16'(out_valid), 16'h0000);
    // Clock enable low freezes the sequencer
    ce = 1'b0;
    fpulse(mc_upconv_pkg::mode_pal_film, 1'b1);
    chk("frozen", 16'({slot_out, mode_out}), 16'h0000);
    ce = 1'b1;
    finish_test;
  end
endmodule : test_mc_upconv
